// ==== verilog/brk_pkg.sv ====
package brk_pkg;
  // Register word addresses (byte address = 4 * index)
  localparam logic [3:0] REG_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] REG_ADDRESS_HIGH   = 4'h1;
  localparam logic [3:0] REG_ADDRESS_LOW    = 4'h2;
  localparam logic [3:0] REG_SYSTEM_CONTROL = 4'h3;
  localparam int         REG_INDEX_LSB      = 2;
  localparam int         REG_INDEX_WIDTH    = 4;
  // Field positions in break_status_control
  localparam int BIT_ENABLE = 7;
  localparam int BIT_ACTIVE = 6;
  // Field positions in the system control register
  localparam int BIT_FLAG_CLEAR_ENABLE = 0;
  localparam int BIT_WAIT_BREAK_STATUS = 1;
  localparam int BIT_MONITOR_MODE      = 2;
  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Vector addresses
  localparam logic [15:0] VECTOR_NORMAL  = 16'hfffc;
  localparam logic [15:0] VECTOR_MONITOR = 16'hfefc;
  // Bus answer when nothing is mapped
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  localparam int          ADDR_WIDTH    = 16;
endpackage

// ==== verilog/brk_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module brk_sync (
  input  wire logic clk_i,    // Clock
  input  wire logic rst_i,    // Async reset, high
  input  wire logic d_i,      // Asynchronous level
  output logic      q_o       // Synchronised level
);
  logic stage1_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stage1_reg <= 1'b0;
      q_o        <= 1'b0;
    end else begin
      stage1_reg <= d_i;
      q_o        <= stage1_reg;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/brk_unit.sv ====
//
// Behaviour
// - Program address equal to stored break address raises breakpoint request.
// - Only CPU-generated program counter addresses are compared.
// - On break, issue software interrupt opcode and vector FFFC or FEFC in monitor.
// - Break begins when current instruction ends; at once if match on last cycle.
// - Interrupt return inside break routine ends the break state.
// - Enable bit 7 is read/write, permits 16-bit match breaks, reset clears.
// - Active bit is read/write, set by hardware on match, reset clears.
// - Writing one to active bit raises break; software clears it before exit.
// - Break address held as high and low bytes, both cleared by reset.
// - Timer counter halted while break is in effect.
// - Watchdog disabled during break when elevated voltage is on reset pin.
// - Peripheral flags clearable during break only with flag clear enable set.
// - I/O registers stay accessible while the break is active.
// - Unit works in wait mode; wait-break status cleared by writing zero.
// - Break wakes from wait and sets wait-break status; stop unsupported here.
//
// Chosen here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module brk_unit (
  input  wire logic        CLOCK_I,              // 100 MHz clock
  input  wire logic        RESET_I,              // Async reset, high
  input  wire logic [5:0]  AVS_ADDRESS_I,        // Byte address
  input  wire logic        AVS_READ_I,           // Read strobe
  input  wire logic        AVS_WRITE_I,          // Write strobe
  input  wire logic [31:0] AVS_WRITEDATA_I,      // Write data
  input  wire logic [3:0]  AVS_BYTEENABLE_I,     // Byte lanes
  output logic [31:0]      AVS_READDATA_O,       // Read data
  output logic             AVS_WAITREQUEST_O,    // Stall
  input  wire logic [15:0] CPU_ADDRESS_I,        // Internal address bus
  input  wire logic        CPU_PC_FETCH_I,       // Address is program counter
  input  wire logic        CPU_LAST_CYCLE_I,     // Last cycle of instruction
  input  wire logic        CPU_RETURN_OP_I,      // Interrupt return executed
  input  wire logic        CPU_WAIT_MODE_I,      // CPU in wait mode
  input  wire logic        HIGH_VOLTAGE_RESET_I, // Elevated voltage on reset pin, async
  output logic             BREAKPOINT_REQUEST_O, // Request to integration unit
  output logic             FORCE_SOFTWARE_INTERRUPT_OP_O, // Load software interrupt opcode
  output logic [15:0]      VECTOR_ADDRESS_O,     // Vector to fetch
  output logic             BREAK_STATE_O,        // Break in effect
  output logic             TIMER_HALT_O,         // Halt timer counter
  output logic             WATCHDOG_DISABLE_O,   // Disable watchdog
  output logic             FLAG_CLEAR_ALLOW_O,   // Peripheral flags may clear
  output logic             WAKE_O                // Wake from wait
);

  typedef enum logic [1:0] {BRK_IDLE, BRK_PENDING, BRK_ACTIVE} brk_state_e;

  brk_state_e  state_reg;
  brk_state_e  state_next;
  logic        enable_reg;
  logic        active_reg;
  logic [7:0]  addr_high_reg;
  logic [7:0]  addr_low_reg;
  logic        flag_clear_reg;
  logic        wait_break_reg;
  logic        monitor_reg;
  logic        ack_reg;
  logic        high_voltage_sync;

  wire logic [3:0]  reg_index;
  wire logic        access_any;
  wire logic        wr_go;
  wire logic        wr_lane0;
  wire logic        wr_status;
  wire logic        wr_high;
  wire logic        wr_low;
  wire logic        wr_system;
  wire logic [15:0] break_address;
  wire logic        address_match;
  wire logic        qualified_match;
  wire logic        soft_break;
  wire logic        break_event;
  wire logic        in_break;
  wire logic        active_next;
  wire logic        wait_break_next;
  wire logic [7:0]  read_byte;
  wire logic [31:0] read_word;

  brk_sync u_hv_sync (
    .clk_i (CLOCK_I),
    .rst_i (RESET_I),
    .d_i   (HIGH_VOLTAGE_RESET_I),
    .q_o   (high_voltage_sync)
  );

  // One wait state: every access completes on the second edge
  assign reg_index  = AVS_ADDRESS_I[brk_pkg::REG_INDEX_LSB +: brk_pkg::REG_INDEX_WIDTH];
  assign access_any = AVS_READ_I | AVS_WRITE_I;
  assign wr_go      = AVS_WRITE_I & ack_reg;
  assign wr_lane0   = wr_go & AVS_BYTEENABLE_I[0];
  assign wr_status  = wr_lane0 & (reg_index == brk_pkg::REG_STATUS_CONTROL);
  assign wr_high    = wr_lane0 & (reg_index == brk_pkg::REG_ADDRESS_HIGH);
  assign wr_low     = wr_lane0 & (reg_index == brk_pkg::REG_ADDRESS_LOW);
  assign wr_system  = wr_lane0 & (reg_index == brk_pkg::REG_SYSTEM_CONTROL);

  assign break_address   = {addr_high_reg, addr_low_reg};
  assign address_match   = CPU_PC_FETCH_I & (CPU_ADDRESS_I == break_address);
  assign qualified_match = address_match & enable_reg;
  // Software break: a write of one to the active bit
  assign soft_break = wr_status & AVS_WRITEDATA_I[brk_pkg::BIT_ACTIVE];
  assign break_event = qualified_match | soft_break;
  assign in_break    = (state_reg == BRK_ACTIVE);

  // Hardware set wins over software clear in the same cycle
  assign active_next = qualified_match ? 1'b1 :
                       wr_status ? AVS_WRITEDATA_I[brk_pkg::BIT_ACTIVE] : active_reg;
  // A break taken from wait mode sets the wait-break status bit
  assign wait_break_next = (break_event & CPU_WAIT_MODE_I) ? 1'b1 :
                           wr_system ? (wait_break_reg &
                             AVS_WRITEDATA_I[brk_pkg::BIT_WAIT_BREAK_STATUS]) :
                           wait_break_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BRK_IDLE: begin
        if (break_event) begin
          state_next = CPU_LAST_CYCLE_I ? BRK_ACTIVE : BRK_PENDING;
        end
      end
      BRK_PENDING: begin
        if (CPU_LAST_CYCLE_I) begin
          state_next = BRK_ACTIVE;
        end
      end
      BRK_ACTIVE: begin
        if (CPU_RETURN_OP_I) begin
          state_next = BRK_IDLE;
        end
      end
      default: state_next = BRK_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_reg <= BRK_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Registers stay writable in every state, break included
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      enable_reg     <= 1'b0;
      active_reg     <= 1'b0;
      addr_high_reg  <= brk_pkg::RESET_BYTE;
      addr_low_reg   <= brk_pkg::RESET_BYTE;
      flag_clear_reg <= 1'b0;
      monitor_reg    <= 1'b0;
      wait_break_reg <= 1'b0;
    end else begin
      active_reg     <= active_next;
      wait_break_reg <= wait_break_next;
      if (wr_status) begin
        enable_reg <= AVS_WRITEDATA_I[brk_pkg::BIT_ENABLE];
      end
      if (wr_high) begin
        addr_high_reg <= AVS_WRITEDATA_I[7:0];
      end
      if (wr_low) begin
        addr_low_reg <= AVS_WRITEDATA_I[7:0];
      end
      if (wr_system) begin
        flag_clear_reg <= AVS_WRITEDATA_I[brk_pkg::BIT_FLAG_CLEAR_ENABLE];
        monitor_reg    <= AVS_WRITEDATA_I[brk_pkg::BIT_MONITOR_MODE];
      end
    end
  end

  assign read_byte =
    (reg_index == brk_pkg::REG_STATUS_CONTROL) ? {enable_reg, active_reg, 6'h00} :
    (reg_index == brk_pkg::REG_ADDRESS_HIGH)   ? addr_high_reg :
    (reg_index == brk_pkg::REG_ADDRESS_LOW)    ? addr_low_reg :
    (reg_index == brk_pkg::REG_SYSTEM_CONTROL) ?
      {5'h00, monitor_reg, wait_break_reg, flag_clear_reg} : 8'h00;
  assign read_word = (reg_index <= brk_pkg::REG_SYSTEM_CONTROL) ?
                     {24'h000000, read_byte} : brk_pkg::UNMAPPED_DATA;

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ack_reg           <= 1'b0;
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O    <= 32'h0000_0000;
    end else begin
      ack_reg           <= access_any & ~ack_reg;
      AVS_WAITREQUEST_O <= ~(access_any & ~ack_reg);
      AVS_READDATA_O    <= (AVS_READ_I & ~ack_reg) ? read_word : 32'h0000_0000;
    end
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      BREAKPOINT_REQUEST_O <= 1'b0;
      FORCE_SOFTWARE_INTERRUPT_OP_O <= 1'b0;
      VECTOR_ADDRESS_O     <= brk_pkg::VECTOR_NORMAL;
      BREAK_STATE_O        <= 1'b0;
      TIMER_HALT_O         <= 1'b0;
      WATCHDOG_DISABLE_O   <= 1'b0;
      FLAG_CLEAR_ALLOW_O   <= 1'b1;
      WAKE_O               <= 1'b0;
    end else begin
      BREAKPOINT_REQUEST_O <= (state_next != BRK_IDLE);
      FORCE_SOFTWARE_INTERRUPT_OP_O <= (state_reg != BRK_ACTIVE) &&
                                       (state_next == BRK_ACTIVE);
      VECTOR_ADDRESS_O     <= monitor_reg ? brk_pkg::VECTOR_MONITOR :
                              brk_pkg::VECTOR_NORMAL;
      BREAK_STATE_O        <= (state_next == BRK_ACTIVE);
      TIMER_HALT_O         <= (state_next == BRK_ACTIVE);
      WATCHDOG_DISABLE_O   <= (state_next == BRK_ACTIVE) & high_voltage_sync;
      FLAG_CLEAR_ALLOW_O   <= (state_next != BRK_ACTIVE) | flag_clear_reg;
      WAKE_O               <= break_event & CPU_WAIT_MODE_I;
    end
  end

  sequence s_break_taken;
    (state_reg == BRK_IDLE) && break_event && CPU_LAST_CYCLE_I;
  endsequence
  sequence s_op_issued;
    ##1 FORCE_SOFTWARE_INTERRUPT_OP_O && TIMER_HALT_O;
  endsequence
  // Match seen in mid-instruction: request now, break only later
  sequence s_break_deferred;
    (state_reg == BRK_IDLE) && break_event && !CPU_LAST_CYCLE_I;
  endsequence
  sequence s_request_only;
    ##1 BREAKPOINT_REQUEST_O && !BREAK_STATE_O && !FORCE_SOFTWARE_INTERRUPT_OP_O;
  endsequence

  AST_MATCH_REQUEST: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (state_reg == BRK_IDLE) && qualified_match |=> BREAKPOINT_REQUEST_O)
    else $error("Match did not raise breakpoint request");
  AST_NO_DATA_MATCH: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (state_reg == BRK_IDLE) && !CPU_PC_FETCH_I && !soft_break |=> !BREAKPOINT_REQUEST_O)
    else $error("Non-PC address raised a break");
  AST_VECTOR: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    FORCE_SOFTWARE_INTERRUPT_OP_O |-> VECTOR_ADDRESS_O ==
      ($past(monitor_reg) ? brk_pkg::VECTOR_MONITOR : brk_pkg::VECTOR_NORMAL))
    else $error("Wrong break vector");
  AST_IMMEDIATE: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    s_break_taken |-> s_op_issued)
    else $error("Break on last cycle did not begin at once");
  AST_WAIT_END: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (state_reg == BRK_PENDING) && !CPU_LAST_CYCLE_I |=> !BREAK_STATE_O)
    else $error("Break began before instruction end");
  AST_RETURN_ENDS: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    in_break && CPU_RETURN_OP_I |=> !BREAK_STATE_O && !TIMER_HALT_O)
    else $error("Interrupt return did not end break");
  AST_ACTIVE_SET: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    qualified_match |=> active_reg)
    else $error("Active bit not set on match");
  AST_SOFT_BREAK: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    soft_break && !(in_break && CPU_RETURN_OP_I) |=> BREAKPOINT_REQUEST_O)
    else $error("Soft break not raised");
  AST_DISABLED: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    !enable_reg && !soft_break && (state_reg == BRK_IDLE) |=> !BREAKPOINT_REQUEST_O)
    else $error("Break while disabled");
  AST_WATCHDOG: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    WATCHDOG_DISABLE_O |-> BREAK_STATE_O && $past(high_voltage_sync))
    else $error("Watchdog disabled outside break or voltage");
  AST_FLAG_GUARD: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    BREAK_STATE_O && !$past(flag_clear_reg) |-> !FLAG_CLEAR_ALLOW_O)
    else $error("Flag clear allowed in break without enable");

  // Break sequencing
  AST_DEFERRED: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    s_break_deferred |-> s_request_only)
    else $error("Break began in mid-instruction");
  AST_PENDING_END: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (state_reg == BRK_PENDING) && CPU_LAST_CYCLE_I |=> BREAK_STATE_O)
    else $error("Pending break did not begin at instruction end");
  AST_NO_RESTART: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    in_break |=> !FORCE_SOFTWARE_INTERRUPT_OP_O)
    else $error("Break restarted while active");
  AST_OP_PULSE: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    FORCE_SOFTWARE_INTERRUPT_OP_O |=> !FORCE_SOFTWARE_INTERRUPT_OP_O)
    else $error("Opcode force longer than one cycle");
  AST_VECTOR_TRACK: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    !$past(monitor_reg) |-> VECTOR_ADDRESS_O == brk_pkg::VECTOR_NORMAL)
    else $error("Monitor vector without monitor mode");
  AST_RETURN_IDLE: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    in_break && CPU_RETURN_OP_I |=> !BREAKPOINT_REQUEST_O && (state_reg == BRK_IDLE))
    else $error("Request left standing after return");

  // Side effects of the break state
  AST_HALT_IN_BREAK: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    in_break |-> BREAK_STATE_O && TIMER_HALT_O)
    else $error("Timer runs during break");
  AST_HALT_FOLLOWS: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    TIMER_HALT_O == BREAK_STATE_O)
    else $error("Timer halt differs from break state");
  AST_WATCHDOG_OFF: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    !BREAK_STATE_O |-> !WATCHDOG_DISABLE_O)
    else $error("Watchdog disabled outside break");
  AST_WATCHDOG_ON: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    (state_next == BRK_ACTIVE) && high_voltage_sync |=> WATCHDOG_DISABLE_O)
    else $error("Watchdog left running in break with high voltage");
  AST_FLAG_OPEN: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    !BREAK_STATE_O |-> FLAG_CLEAR_ALLOW_O)
    else $error("Flag clear blocked outside break");

  // Register side
  AST_ENABLE_WRITE: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    wr_status |=> enable_reg == $past(AVS_WRITEDATA_I[brk_pkg::BIT_ENABLE]))
    else $error("Enable bit not written");
  AST_ACTIVE_CLEAR: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    wr_status && !AVS_WRITEDATA_I[brk_pkg::BIT_ACTIVE] && !qualified_match |=> !active_reg)
    else $error("Active bit not cleared by software");
  AST_DISABLED_ACTIVE: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    !enable_reg && !wr_status |=> active_reg == $past(active_reg))
    else $error("Active bit moved while disabled");
  AST_ADDR_HIGH: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    wr_high |=> addr_high_reg == $past(AVS_WRITEDATA_I[7:0]))
    else $error("High address byte not written");
  AST_ADDR_LOW: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    wr_low |=> addr_low_reg == $past(AVS_WRITEDATA_I[7:0]))
    else $error("Low address byte not written");
  // A stalled bus would lock the background routine out
  AST_ONE_WAIT: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    access_any && !ack_reg |=> !AVS_WAITREQUEST_O)
    else $error("Access not answered after one wait state");
  AST_WAIT_PULSE: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("Waitrequest low for more than one cycle");
  AST_READ_QUIET: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    AVS_WAITREQUEST_O |-> AVS_READDATA_O == 32'h0000_0000)
    else $error("Read data outside answer cycle");

  // Wait mode
  AST_WAIT_SET: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    break_event && CPU_WAIT_MODE_I |=> wait_break_reg)
    else $error("Wait-break status not set");
  AST_WAIT_CLEAR: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    wr_system && !AVS_WRITEDATA_I[brk_pkg::BIT_WAIT_BREAK_STATUS] &&
    !(break_event && CPU_WAIT_MODE_I) |=> !wait_break_reg)
    else $error("Wait-break status not cleared");
  AST_WAKE: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    break_event && CPU_WAIT_MODE_I |=> WAKE_O)
    else $error("Break did not wake the core");

endmodule
`default_nettype wire

// ==== test/brk_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module brk_cpu_model (
  input  wire logic        clk_i,   // Clock
  input  wire logic        rst_i,   // Reset
  input  wire logic        load_i,  // Jump to start_i
  input  wire logic [15:0] start_i, // Jump target
  input  wire logic [15:0] decoy_i, // Operand address
  input  wire logic [2:0]  len_i,   // Cycles per instruction
  input  wire logic        brk_i,   // Break in effect
  input  wire logic        leave_i, // Routine may return
  output logic [15:0]      addr_o,  // Address bus
  output logic             fetch_o, // Program counter on bus
  output logic             last_o,  // Final instruction cycle
  output logic             ret_o    // Return op pulse
);
  logic [15:0] pc_reg;
  logic [2:0]  cyc_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_reg  <= 16'h0000;
      cyc_reg <= 3'h0;
      addr_o  <= 16'h0000;
      fetch_o <= 1'b0;
      last_o  <= 1'b0;
      ret_o   <= 1'b0;
    end else if (brk_i) begin
      // Bus keeps moving so a stale address can never match
      cyc_reg <= 3'h0;
      fetch_o <= 1'b0;
      last_o  <= 1'b0;
      addr_o  <= ~addr_o;
      ret_o   <= leave_i & ~ret_o;
    end else begin
      ret_o   <= 1'b0;
      fetch_o <= (cyc_reg == 3'h0);
      addr_o  <= (cyc_reg == 3'h0) ? pc_reg : decoy_i;
      last_o  <= (cyc_reg == len_i - 3'h1);
      cyc_reg <= (cyc_reg == len_i - 3'h1) ? 3'h0 : cyc_reg + 3'h1;
      if (load_i)
        pc_reg <= start_i;
      else if (cyc_reg == 3'h0)
        pc_reg <= pc_reg + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ==== test/brk_unit_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h exp %h", $time, a, b); end end
module brk_unit_tb;
  logic        clk = 1'b0, rst = 1'b1, rd_s = 1'b0, wr_s = 1'b0, load = 1'b0;
  logic        wmode = 1'b0, hv = 1'b0, leave = 1'b0, woke = 1'b0;
  logic [5:0]  adr = 6'h00;
  logic [31:0] wd = 32'h0, rdat;
  logic [3:0]  be = 4'hf;
  logic [2:0]  len = 3'h1;
  logic [15:0] start = 16'h8000, decoy = 16'h0000, cadr, vec, t;
  logic        fetch, last, ret, wq, req, fsi, bst, thalt, wdog, fca, wake;
  logic        en, act, fce, wbs, mon, m_req, m_brk, m_fsi, m_woke, mt, ev, wr;
  logic [7:0]  bh, bl, d, q;
  int          n_mismatch = 0, n_tests = 0;

  always #5 clk = ~clk;

  brk_unit u_brk_unit (.CLOCK_I(clk), .RESET_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd_s),
    .AVS_WRITE_I(wr_s), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wq), .CPU_ADDRESS_I(cadr), .CPU_PC_FETCH_I(fetch),
    .CPU_LAST_CYCLE_I(last), .CPU_RETURN_OP_I(ret), .CPU_WAIT_MODE_I(wmode),
    .HIGH_VOLTAGE_RESET_I(hv), .BREAKPOINT_REQUEST_O(req),
    .FORCE_SOFTWARE_INTERRUPT_OP_O(fsi),
    .VECTOR_ADDRESS_O(vec), .BREAK_STATE_O(bst), .TIMER_HALT_O(thalt),
    .WATCHDOG_DISABLE_O(wdog), .FLAG_CLEAR_ALLOW_O(fca), .WAKE_O(wake));
  brk_cpu_model u_brk_cpu_model (.clk_i(clk), .rst_i(rst), .load_i(load), .start_i(start),
    .decoy_i(decoy), .len_i(len), .brk_i(bst), .leave_i(leave), .addr_o(cadr),
    .fetch_o(fetch), .last_o(last), .ret_o(ret));

  // Reference model, updated on the same edges as the design's flops
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {en, act, fce, wbs, mon, m_req, m_brk, m_fsi, m_woke, bh, bl} = '0;
    end else begin
      wr = wr_s && !wq && be[0];
      d = wd[7:0];
      mt = fetch && cadr == {bh, bl} && en;
      ev = mt || (wr && adr == 6'h00 && d[6]);
      m_fsi = !m_brk && (m_req || ev) && last;
      m_woke = m_woke | (ev & wmode);
      if (wr && adr == 6'h00) {en, act} = d[7:6];
      if (wr && adr == 6'h04) bh = d;
      if (wr && adr == 6'h08) bl = d;
      if (wr && adr == 6'h0c) {mon, wbs, fce} = {d[2], wbs & d[1], d[0]};
      act = act | mt;
      wbs = wbs | (ev & wmode);
      m_req = m_brk ? !ret : (m_req || ev);
      m_brk = m_brk ? !ret : m_fsi;
    end
  end

  always @(negedge clk) if (!rst) begin
    `CHK(req, m_req)
    `CHK(bst, m_brk)
    `CHK(thalt, m_brk)
    `CHK(fsi, m_fsi)
    woke = woke | wake;
  end

  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] dv);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= {24'h0, dv};
    wr_s <= w;
    rd_s <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 20);
    if (n >= 20) n_mismatch++;
    q = rdat[7:0];
    wr_s <= 1'b0;
    rd_s <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(q, e)
  endtask

  task automatic wt(input logic v);
    int n;
    n = 0;
    while (bst !== v && n < 60) begin
      @(posedge clk);
      n++;
    end
    if (n >= 60) n_mismatch++;
  endtask

  task automatic side();
    repeat (4) @(posedge clk);
    `CHK(vec, mon ? brk_pkg::VECTOR_MONITOR : brk_pkg::VECTOR_NORMAL)
    `CHK(wdog, m_brk & hv)
    `CHK(fca, !m_brk | fce)
  endtask

  task automatic test_done();
    if (n_mismatch == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #100us;
    n_mismatch++;
    test_done();
  end

  initial begin
    void'($urandom(32'h1b4b));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    side();
    for (int i = 0; i < 16; i++) rd(6'(i * 4), 8'h00);
    be <= 4'h0;
    bus(1'b1, 6'h04, 8'hff);
    be <= 4'hf;
    rd(6'h04, 8'h00);
    for (int k = 1; k <= 4; k++) begin
      t = 16'($urandom);
      decoy <= t;
      len <= 3'(k);
      wmode <= k[0];
      hv <= k[1];
      bus(1'b1, 6'h04, t[15:8]);
      bus(1'b1, 6'h08, t[7:0]);
      rd(6'h04, t[15:8]);
      rd(6'h08, t[7:0]);
      for (int p = 0; p < 2; p++) begin
        // Disabled pass must walk over the target without a break
        if (p == 1 && k < 4) bus(1'b1, 6'h00, 8'h80);
        if (p == 1 && k == 4) bus(1'b1, 6'h00, 8'h40);
        start <= t - 16'h0003;
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
        repeat (8 * k) @(posedge clk);
      end
      wt(1'b1);
      rd(6'h00, {en, act, 6'h00});
      rd(6'h0c, {5'h00, mon, wbs, fce});
      bus(1'b1, 6'h0c, 8'($urandom) & 8'h05);
      side();
      bus(1'b1, 6'h00, 8'h00);
      rd(6'h0c, {5'h00, mon, wbs, fce});
      leave <= 1'b1;
      wt(1'b0);
      leave <= 1'b0;
      side();
    end
    `CHK(woke, m_woke)
    test_done();
  end
endmodule
`default_nettype wire
